// *** design/frb_pkg.sv ***
// Constants, types and register map of the flash read buffer block.
// Assumes one 25 MHz core clock and a synchronous active-high reset.
package frb_pkg;
  localparam int NBUF = 6;
  // Register offsets on the plain register port.
  localparam logic [3:0] REG_ACR  = 4'h0;
  localparam logic [3:0] REG_SR   = 4'h4;
  localparam logic [3:0] REG_PCTL = 4'h8;
  // Field positions.
  localparam int ACR_NOBUF = 0;
  localparam int ACR_PFEN  = 1;
  localparam int ACR_PREN  = 2;
  localparam int SR_BUSY   = 0;
  localparam int SR_EOP    = 1;
  localparam int PCTL_MULT = 0;
  // Reset values.
  localparam logic [2:0] ACR_RST  = 3'h0;
  localparam logic       PCTL_RST = 1'h0;
  // Address step of a speculative read and program stall length.
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0]  STALL_CYC = 2'h3;
  // Age value that stands for an empty entry.
  localparam logic [1:0] AGE_NONE = 2'h3;
  localparam logic [1:0] AGE_NEW  = 2'h0;
  // Groups and fixed entry roles.
  localparam logic [2:0] GRP_JMP = 3'h0;
  localparam logic [2:0] GRP_PF  = 3'h1;
  localparam logic [2:0] GRP_LF  = 3'h2;
  localparam logic [2:0] GRP_LD  = 3'h3;
  localparam logic [2:0] GRP_PR  = 3'h4;
  localparam logic [2:0] IDX_PF  = 3'h2;
  localparam logic [2:0] IDX_LF  = 3'h3;
  localparam logic [2:0] IDX_LD  = 3'h4;
  localparam logic [2:0] IDX_PR  = 3'h5;

  typedef struct packed {
    logic [28:0] tag;
    logic [63:0] data;
  } frb_line_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        fetch;
  } frb_rreq_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_MRD    = 5'h02,
    ST_SPEC   = 5'h04,
    ST_PSTALL = 5'h08,
    ST_PROG   = 5'h10
  } frb_st_t;
endpackage

// *** design/frb_top.sv ***
// Read buffers, speculative reads and single-word program start of a flash interface.
// Assumes the array and the master share core_clk; the master keeps one request open.
module frb_top (
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Register port.
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata_ff,
  // Master reads.
  input  wire logic               mst_rd,
  input  frb_pkg::frb_rreq_t      mst_req,
  output logic                    mst_rvalid_ff,
  output logic      [31:0]        mst_rdata_ff,
  // Master program writes.
  input  wire logic               mst_wr,
  input  wire logic [31:0]        mst_waddr,
  input  wire logic [31:0]        mst_wdata,
  output logic                    mst_wdone_ff,
  // Array side.
  output logic                    arr_rd_ff,
  output logic                    arr_pg_ff,
  output logic      [31:0]        arr_addr_ff,
  output logic      [31:0]        arr_wdata_ff,
  input  wire logic               arr_ack,
  input  wire logic [63:0]        arr_rdata,
  input  wire logic               arr_pg_done
);
  frb_pkg::frb_st_t   st_ff;
  frb_pkg::frb_line_t line_ff [frb_pkg::NBUF];
  logic [1:0]         age_ff  [frb_pkg::NBUF];
  logic [2:0]         grp     [frb_pkg::NBUF];
  logic [frb_pkg::NBUF-1:0] vld_ff;
  logic [frb_pkg::NBUF-1:0] hit_vec;
  logic [frb_pkg::NBUF-1:0] pg_match;
  logic [2:0]         acr_ff;
  logic               mult_ff;
  logic               op_mult_ff;
  logic               eop_ff;
  logic               pend_rd_ff;
  frb_pkg::frb_rreq_t pend_ff;
  logic               pend_wr_ff;
  logic [31:0]        pw_addr_ff;
  logic [31:0]        pw_data_ff;
  logic               pf_arm_ff;
  logic               pr_arm_ff;
  logic [31:0]        pf_addr_ff;
  logic [31:0]        pr_addr_ff;
  logic               spec_fetch_ff;
  logic [1:0]         cnt_ff;
  logic               nobuf;
  logic               pfen;
  logic               pren;
  logic               hit_any;
  logic [2:0]         hit_idx;
  logic [2:0]         vic_idx;
  logic [2:0]         fill_grp;
  logic [1:0]         vic_age;
  logic               vic_free;
  logic               serve_hit;
  logic               cp_en;
  logic [2:0]         cp_dst;
  logic               fill_en;
  logic               tch_en;
  logic [2:0]         tch_idx;
  logic [1:0]         tch_old;
  logic               abort;
  logic               inval_all;
  logic               pg_fin;
  logic               launch_pf;
  logic               launch_pr;
  logic               mrd_done;
  logic               age_clash;

  assign nobuf = acr_ff[frb_pkg::ACR_NOBUF];
  assign pfen  = acr_ff[frb_pkg::ACR_PFEN] && !nobuf;
  assign pren  = acr_ff[frb_pkg::ACR_PREN] && !nobuf;
  assign pg_fin = (st_ff == frb_pkg::ST_PROG) && arr_pg_done;
  assign inval_all = pg_fin && op_mult_ff;

  // Role of each entry under the current configuration.
  always_comb begin
    grp[0] = frb_pkg::GRP_JMP;
    grp[1] = frb_pkg::GRP_JMP;
    grp[2] = pfen ? frb_pkg::GRP_PF : frb_pkg::GRP_JMP;
    grp[3] = frb_pkg::GRP_LF;
    grp[4] = frb_pkg::GRP_LD;
    grp[5] = pren ? frb_pkg::GRP_PR : frb_pkg::GRP_LD;
  end

  // Lookup over all six entries, whatever the group or read kind.
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 3'h0;
    for (int i = frb_pkg::NBUF - 1; i >= 0; i--) begin
      hit_vec[i]  = vld_ff[i] && !nobuf && (line_ff[i].tag == pend_ff.addr[31:3]);
      pg_match[i] = vld_ff[i] && (line_ff[i].tag == arr_addr_ff[31:3]);
      if (hit_vec[i]) begin
        hit_any = 1'b1;
        hit_idx = 3'(i);
      end
    end
  end

  // Victim: first empty entry of the group, else its oldest.
  always_comb begin
    if (st_ff == frb_pkg::ST_SPEC) begin
      fill_grp = spec_fetch_ff ? frb_pkg::GRP_PF : frb_pkg::GRP_PR;
    end else begin
      fill_grp = pend_ff.fetch ? frb_pkg::GRP_JMP : frb_pkg::GRP_LD;
    end
    vic_idx  = 3'h0;
    vic_age  = frb_pkg::AGE_NEW;
    vic_free = 1'b0;
    for (int i = 0; i < frb_pkg::NBUF; i++) begin
      if (grp[i] == fill_grp && !vic_free) begin
        if (!vld_ff[i]) begin
          vic_idx  = 3'(i);
          vic_free = 1'b1;
        end else if (age_ff[i] >= vic_age) begin
          vic_idx = 3'(i);
          vic_age = age_ff[i];
        end
      end
    end
  end

  assign serve_hit = (st_ff == frb_pkg::ST_IDLE) && pend_rd_ff && !pend_wr_ff && hit_any;
  assign cp_en = serve_hit && ((hit_idx == frb_pkg::IDX_PF && pfen && pend_ff.fetch)
               || (hit_idx == frb_pkg::IDX_PR && pren && !pend_ff.fetch));
  assign cp_dst = (hit_idx == frb_pkg::IDX_PF) ? frb_pkg::IDX_LF : frb_pkg::IDX_LD;
  assign mrd_done = (st_ff == frb_pkg::ST_MRD) && arr_ack;
  assign fill_en = (mrd_done || (st_ff == frb_pkg::ST_SPEC && arr_ack)) && !nobuf;
  assign tch_en  = serve_hit || fill_en;
  assign tch_idx = fill_en ? vic_idx : (cp_en ? cp_dst : hit_idx);
  assign tch_old = vld_ff[tch_idx] ? age_ff[tch_idx] : frb_pkg::AGE_NONE;
  assign abort = (st_ff == frb_pkg::ST_SPEC) && !arr_ack && (pend_wr_ff
               || (pend_rd_ff && pend_ff.addr[31:3] != arr_addr_ff[31:3]));
  assign launch_pf = (st_ff == frb_pkg::ST_IDLE) && !pend_rd_ff && !pend_wr_ff
                   && pf_arm_ff && pfen;
  assign launch_pr = (st_ff == frb_pkg::ST_IDLE) && !pend_rd_ff && !pend_wr_ff
                   && !(pf_arm_ff && pfen) && pr_arm_ff && pren;

  // Entry contents, 64 bits wide.
  always_ff @(posedge core_clk) begin
    if (fill_en) begin
      line_ff[vic_idx] <= '{tag: arr_addr_ff[31:3], data: arr_rdata};
    end else if (cp_en) begin
      line_ff[cp_dst] <= line_ff[hit_idx];
    end
  end

  // Valid bits.
  always_ff @(posedge core_clk) begin
    if (sys_rst || inval_all || (reg_wr && reg_addr == frb_pkg::REG_ACR)) begin
      vld_ff <= '0;
    end else if (pg_fin) begin
      vld_ff <= vld_ff & ~pg_match;
    end else if (fill_en) begin
      if (mrd_done && pfen && pend_ff.fetch) begin
        vld_ff[frb_pkg::IDX_PF] <= 1'b0;
      end
      vld_ff[vic_idx] <= 1'b1;
    end else if (cp_en) begin
      vld_ff[cp_dst]  <= 1'b1;
      vld_ff[hit_idx] <= 1'b0;
    end else if (serve_hit && pfen && pend_ff.fetch && hit_idx != frb_pkg::IDX_PF) begin
      vld_ff[frb_pkg::IDX_PF] <= 1'b0;
    end
  end

  // Age histories, one per entry, ordered within its group.
  generate
    for (genvar g = 0; g < frb_pkg::NBUF; g++) begin : g_age
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          age_ff[g] <= frb_pkg::AGE_NONE;
        end else if (tch_en && tch_idx == 3'(g)) begin
          age_ff[g] <= frb_pkg::AGE_NEW;
        end else if (tch_en && vld_ff[g] && grp[g] == grp[tch_idx] && age_ff[g] < tch_old) begin
          age_ff[g] <= age_ff[g] + 2'h1;
        end
      end
    end
  endgenerate

  // Software registers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acr_ff  <= frb_pkg::ACR_RST;
      mult_ff <= frb_pkg::PCTL_RST;
      eop_ff  <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == frb_pkg::REG_ACR) begin
        acr_ff <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == frb_pkg::REG_PCTL) begin
        mult_ff <= reg_wdata[frb_pkg::PCTL_MULT];
      end
      if (pg_fin) begin
        eop_ff <= 1'b1;
      end else if (reg_wr && reg_addr == frb_pkg::REG_SR && reg_wdata[frb_pkg::SR_EOP]) begin
        eop_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata_ff <= '0;
    end else begin
      unique case (reg_addr)
        frb_pkg::REG_ACR:  reg_rdata_ff <= {29'h0, acr_ff};
        frb_pkg::REG_SR:   reg_rdata_ff <= {30'h0, eop_ff,
                                            st_ff == frb_pkg::ST_PROG || st_ff == frb_pkg::ST_PSTALL};
        frb_pkg::REG_PCTL: reg_rdata_ff <= {31'h0, mult_ff};
        default:           reg_rdata_ff <= '0;
      endcase
    end
  end

  // Pending master requests.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_rd_ff <= 1'b0;
      pend_ff    <= '0;
    end else if (mst_rd) begin
      pend_rd_ff <= 1'b1;
      pend_ff    <= mst_req;
    end else if (serve_hit || mrd_done) begin
      pend_rd_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_wr_ff <= 1'b0;
      pw_addr_ff <= '0;
      pw_data_ff <= '0;
    end else if (mst_wr) begin
      pend_wr_ff <= 1'b1;
      pw_addr_ff <= mst_waddr;
      pw_data_ff <= mst_wdata;
    end else if (st_ff == frb_pkg::ST_IDLE) begin
      pend_wr_ff <= 1'b0;
    end
  end

  // Lookahead arming.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pf_arm_ff  <= 1'b0;
      pr_arm_ff  <= 1'b0;
      pf_addr_ff <= '0;
      pr_addr_ff <= '0;
    end else begin
      if ((serve_hit || mrd_done) && pend_ff.fetch) begin
        pf_arm_ff  <= pfen;
        pf_addr_ff <= {pend_ff.addr[31:2], 2'h0} + frb_pkg::WORD_STEP;
      end else if (launch_pf) begin
        pf_arm_ff <= 1'b0;
      end
      if ((serve_hit || mrd_done) && !pend_ff.fetch) begin
        pr_arm_ff  <= pren;
        pr_addr_ff <= {pend_ff.addr[31:2], 2'h0} + frb_pkg::WORD_STEP;
      end else if (launch_pr) begin
        pr_arm_ff <= 1'b0;
      end
    end
  end

  // Sequencer toward the array and the master.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff         <= frb_pkg::ST_IDLE;
      arr_rd_ff     <= 1'b0;
      arr_pg_ff     <= 1'b0;
      arr_addr_ff   <= '0;
      arr_wdata_ff  <= '0;
      mst_rvalid_ff <= 1'b0;
      mst_rdata_ff  <= '0;
      mst_wdone_ff  <= 1'b0;
      spec_fetch_ff <= 1'b0;
      cnt_ff        <= '0;
      op_mult_ff    <= 1'b0;
    end else begin
      mst_rvalid_ff <= 1'b0;
      mst_wdone_ff  <= 1'b0;
      unique case (st_ff)
        frb_pkg::ST_IDLE: begin
          if (pend_wr_ff) begin
            st_ff  <= frb_pkg::ST_PSTALL;
            cnt_ff <= '0;
          end else if (serve_hit) begin
            mst_rvalid_ff <= 1'b1;
            mst_rdata_ff  <= pend_ff.addr[2] ? line_ff[hit_idx].data[63:32]
                                             : line_ff[hit_idx].data[31:0];
          end else if (pend_rd_ff) begin
            st_ff       <= frb_pkg::ST_MRD;
            arr_rd_ff   <= 1'b1;
            arr_addr_ff <= pend_ff.addr;
          end else if (launch_pf || launch_pr) begin
            st_ff         <= frb_pkg::ST_SPEC;
            arr_rd_ff     <= 1'b1;
            spec_fetch_ff <= launch_pf;
            arr_addr_ff   <= launch_pf ? pf_addr_ff : pr_addr_ff;
          end
        end
        frb_pkg::ST_MRD: begin
          if (arr_ack) begin
            st_ff         <= frb_pkg::ST_IDLE;
            arr_rd_ff     <= 1'b0;
            mst_rvalid_ff <= 1'b1;
            mst_rdata_ff  <= arr_addr_ff[2] ? arr_rdata[63:32] : arr_rdata[31:0];
          end
        end
        frb_pkg::ST_SPEC: begin
          if (arr_ack || abort) begin
            st_ff     <= frb_pkg::ST_IDLE;
            arr_rd_ff <= 1'b0;
          end
        end
        frb_pkg::ST_PSTALL: begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == frb_pkg::STALL_CYC - 2'h1) begin
            st_ff        <= frb_pkg::ST_PROG;
            arr_pg_ff    <= 1'b1;
            arr_addr_ff  <= pw_addr_ff;
            arr_wdata_ff <= pw_data_ff;
            mst_wdone_ff <= 1'b1;
            op_mult_ff   <= mult_ff;
          end
        end
        frb_pkg::ST_PROG: begin
          if (arr_pg_done) begin
            st_ff     <= frb_pkg::ST_IDLE;
            arr_pg_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // Helper flag for the age checks.
  always_comb begin
    age_clash = 1'b0;
    for (int i = 0; i < frb_pkg::NBUF; i++) begin
      for (int j = i + 1; j < frb_pkg::NBUF; j++) begin
        if (vld_ff[i] && vld_ff[j] && grp[i] == grp[j] && age_ff[i] == age_ff[j]) begin
          age_clash = 1'b1;
        end
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_multi_inval: assert property (inval_all |=> vld_ff == '0)
    else $error("Multi-address operation left a buffer valid.");
  chk_single_inval: assert property (pg_fin && !op_mult_ff
    && !(reg_wr && reg_addr == frb_pkg::REG_ACR) |=>
    vld_ff == ($past(vld_ff) & ~$past(pg_match)))
    else $error("Single program changed the wrong buffers.");
  chk_group_size: assert property (pfen |-> grp[2] == frb_pkg::GRP_PF && grp[1] == grp[0])
    else $error("Prefetch group layout wrong.");
  chk_age_unique: assert property (!age_clash)
    else $error("Two entries of one group share an age.");
  chk_touch_new: assert property (tch_en |=> age_ff[$past(tch_idx)] == frb_pkg::AGE_NEW)
    else $error("Touched entry is not newest.");
  chk_bypass_read: assert property (nobuf && st_ff == frb_pkg::ST_IDLE && pend_rd_ff
    && !pend_wr_ff |=> st_ff == frb_pkg::ST_MRD)
    else $error("Read not sent to array with buffers off.");
  chk_pf_launch: assert property (launch_pf |=> arr_rd_ff
    && arr_addr_ff == $past(pf_addr_ff) && !pf_arm_ff)
    else $error("Prefetch address or arming wrong.");
  chk_spec_abort: assert property (abort |=> !arr_rd_ff ##1 st_ff != frb_pkg::ST_SPEC)
    else $error("Speculative read not aborted.");
  chk_pr_order: assert property (pf_arm_ff && pfen |-> !launch_pr)
    else $error("Pre-read launched ahead of prefetch.");
  chk_prog_stall: assert property (st_ff == frb_pkg::ST_IDLE && pend_wr_ff |->
    ##4 arr_pg_ff && mst_wdone_ff)
    else $error("Program latch not after stall.");
  chk_eop_rise: assert property (pg_fin |=> eop_ff)
    else $error("End-of-operation flag not set.");

  cov_hit: cover property (serve_hit);
  cov_pf_copy: cover property (cp_en && pend_ff.fetch);
  cov_abort: cover property (abort);
  cov_prog: cover property (pg_fin);
endmodule

// *** test/frb_arr_model.sv ***
// Behavioural flash array answering reads and programs of the buffer block.
// Assumes one clock shared with the block; read latency is set by rd_dly.
module frb_arr_model (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Requests from the block, and the read latency from the bench.
  input  wire logic        arr_rd_ff,
  input  wire logic        arr_pg_ff,
  input  wire logic [31:0] arr_addr_ff,
  input  wire logic [31:0] arr_wdata_ff,
  input  wire logic [7:0]  rd_dly,
  // Answers to the block, and the count of answered reads for the bench.
  output logic             arr_ack,
  output logic [63:0]      arr_rdata,
  output logic             arr_pg_done,
  output int               rd_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [31:0]];
  logic [7:0]  cnt;
  logic [3:0]  pcnt;
  function automatic logic [31:0] word(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : (a ^ 32'h5A5A_0000);
  endfunction
  // One answer per request, none after an abort; idle data keeps toggling.
  always @(posedge core_clk) begin
    arr_ack <= 1'b0;
    arr_rdata <= ~arr_rdata;
    if (sys_rst) begin
      cnt <= 8'h0;
      rd_cnt <= 0;
      arr_rdata <= 64'h0;
    end else if (arr_ack || !arr_rd_ff) begin
      cnt <= 8'h0;
    end else if (cnt + 8'h1 >= rd_dly) begin
      arr_ack <= 1'b1;
      arr_rdata <= {word({arr_addr_ff[31:3], 3'h4}), word({arr_addr_ff[31:3], 3'h0})};
      rd_cnt <= rd_cnt + 1;
      cnt <= 8'h0;
    end else begin
      cnt <= cnt + 8'h1;
    end
  end
  // Programs store the word and report done after a fixed time.
  always @(posedge core_clk) begin
    arr_pg_done <= 1'b0;
    if (sys_rst || arr_pg_done || !arr_pg_ff) begin
      pcnt <= 4'h0;
    end else if (pcnt == 4'hF) begin
      arr_pg_done <= 1'b1;
      mem[{arr_addr_ff[31:2], 2'h0}] = arr_wdata_ff;
    end else begin
      pcnt <= pcnt + 4'h1;
    end
  end
endmodule

// *** test/tb.sv ***
// Self-checking bench for the flash read buffer block.
// Assumes frb_top and the behavioural array model frb_arr_model.
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [3:0]         reg_addr = 4'h0;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [31:0]        reg_rdata_ff;
  logic               mst_rd = 1'b0;
  frb_pkg::frb_rreq_t mst_req = '0;
  logic               mst_rvalid_ff;
  logic [31:0]        mst_rdata_ff;
  logic               mst_wr = 1'b0;
  logic [31:0]        mst_waddr = 32'h0;
  logic [31:0]        mst_wdata = 32'h0;
  logic               mst_wdone_ff, arr_rd_ff, arr_pg_ff, arr_ack, arr_pg_done;
  logic [31:0]        arr_addr_ff, arr_wdata_ff;
  logic [63:0]        arr_rdata;
  logic [7:0]         rd_dly = 8'h2;
  int                 rd_cnt, c0, cyc = 0, failures = 0, total_checks = 0;
  logic [31:0]        pmem [logic [31:0]];
  logic [31:0]        seed = 32'h51;

  frb_top DUT (
    .core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
    .mst_rd, .mst_req, .mst_rvalid_ff, .mst_rdata_ff, .mst_wr, .mst_waddr,
    .mst_wdata, .mst_wdone_ff, .arr_rd_ff, .arr_pg_ff, .arr_addr_ff,
    .arr_wdata_ff, .arr_ack, .arr_rdata, .arr_pg_done
  );
  frb_arr_model u_arr (
    .core_clk, .sys_rst, .arr_rd_ff, .arr_pg_ff, .arr_addr_ff, .arr_wdata_ff,
    .rd_dly, .arr_ack, .arr_rdata, .arr_pg_done, .rd_cnt
  );

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end

  function automatic logic [31:0] ew(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'h0};
    return pmem.exists(w) ? pmem[w] : (w ^ 32'h5A5A_0000);
  endfunction
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata_ff)
  endtask
  // Reads one word, checks its value and, when n is not negative, the array reads.
  task automatic rd(input logic [31:0] a, input logic f, input int n);
    int k;
    @(posedge core_clk);
    mst_req <= '{addr: a, fetch: f};
    mst_rd <= 1'b1;
    @(posedge core_clk);
    mst_rd <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (mst_rvalid_ff !== 1'b1 && k < 300);
    `CHK("rdata", ew(a), mst_rdata_ff)
    if (n >= 0) `CHK("arr_reads", n, rd_cnt - c0)
  endtask
  task automatic prog(input logic [31:0] a, input logic [31:0] d, input int st);
    int k;
    @(posedge core_clk);
    mst_waddr <= a;
    mst_wdata <= d;
    mst_wr <= 1'b1;
    @(posedge core_clk);
    mst_wr <= 1'b0;
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (mst_wdone_ff !== 1'b1 && k < 300);
    if (st > 0) `CHK("stall_cycles", st, k)
    pmem[{a[31:2], 2'h0}] = d;
  endtask
  task automatic wait_eop();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      reg_addr <= frb_pkg::REG_SR;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      k++;
    end while (reg_rdata_ff[frb_pkg::SR_EOP] !== 1'b1 && k < 100);
    `CHK("eop", 1'b1, reg_rdata_ff[frb_pkg::SR_EOP])
    reg_w(frb_pkg::REG_SR, 32'h2);
  endtask

  initial begin
    logic [31:0] r;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    reg_r(frb_pkg::REG_ACR, 32'h0);
    reg_r(frb_pkg::REG_SR, 32'h0);
    reg_r(frb_pkg::REG_PCTL, 32'h0);
    reg_w(4'hC, 32'hFFFF_FFFF);
    reg_r(4'hC, 32'h0);
    reg_w(frb_pkg::REG_SR, 32'h1);
    reg_r(frb_pkg::REG_SR, 32'h0);
    reg_w(frb_pkg::REG_ACR, 32'h7);
    reg_r(frb_pkg::REG_ACR, 32'h7);
    tend("registers");
    c0 = rd_cnt;
    rd(32'h700, 1'b1, 1);
    rd(32'h700, 1'b1, 2);
    rd(32'h704, 1'b0, 3);
    repeat (30) @(posedge core_clk);
    `CHK("arr_reads", 3, rd_cnt - c0)
    tend("buffers_off");
    reg_w(frb_pkg::REG_ACR, 32'h0);
    c0 = rd_cnt;
    rd(32'h800, 1'b1, 1);
    rd(32'h810, 1'b1, 2);
    rd(32'h822, 1'b1, 3);
    rd(32'h800, 1'b1, 3);
    rd(32'h830, 1'b1, 4);
    rd(32'h804, 1'b1, 4);
    rd(32'h810, 1'b1, 5);
    rd(32'h800, 1'b0, 5);
    rd(32'h900, 1'b0, 6);
    rd(32'h910, 1'b0, 7);
    rd(32'h900, 1'b0, 7);
    rd(32'h920, 1'b0, 8);
    rd(32'h900, 1'b0, 8);
    rd(32'h910, 1'b0, 9);
    tend("groups");
    // Configure, send the data, then wait for completion.
    reg_w(frb_pkg::REG_PCTL, 32'h0);
    prog(32'h804, 32'h1234_5678, int'(frb_pkg::STALL_CYC) + 1);
    wait_eop();
    reg_r(frb_pkg::REG_SR, 32'h0);
    rd(32'h804, 1'b1, 10);
    rd(32'h900, 1'b0, 10);
    prog(32'h910, 32'hCAFE_0001, 0);
    reg_w(frb_pkg::REG_PCTL, 32'h1);
    prog(32'h914, 32'hCAFE_0002, 0);
    wait_eop();
    wait_eop();
    reg_w(frb_pkg::REG_PCTL, 32'h0);
    rd(32'h900, 1'b0, 11);
    rd(32'h914, 1'b0, 12);
    tend("program");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    c0 = 0;
    rd(32'h804, 1'b1, 1);
    tend("reset");
    reg_w(frb_pkg::REG_ACR, 32'h2);
    c0 = rd_cnt;
    rd(32'hA04, 1'b1, 1);
    repeat (60) @(posedge core_clk);
    `CHK("arr_reads", 2, rd_cnt - c0)
    rd(32'hA08, 1'b1, 2);
    repeat (30) @(posedge core_clk);
    c0 = rd_cnt;
    rd(32'hB04, 1'b1, 1);
    repeat (30) @(posedge core_clk);
    rd(32'hB08, 1'b1, 2);
    rd_dly <= 8'h28;
    reg_w(frb_pkg::REG_ACR, 32'h2);
    c0 = rd_cnt;
    rd(32'hC04, 1'b1, 1);
    repeat (3) @(posedge core_clk);
    rd(32'hD00, 1'b0, 2);
    rd_dly <= 8'h2;
    tend("prefetch");
    reg_w(frb_pkg::REG_ACR, 32'h4);
    c0 = rd_cnt;
    rd(32'hE04, 1'b0, 1);
    repeat (30) @(posedge core_clk);
    `CHK("arr_reads", 2, rd_cnt - c0)
    rd(32'hE08, 1'b0, 2);
    tend("pre_read");
    for (int i = 0; i < 40; i++) begin
      r = xs();
      if (i % 8 == 0) reg_w(frb_pkg::REG_ACR, {29'h0, r[10:8]});
      rd(32'hF00 + {26'h0, r[5:1], 1'b0}, r[0], -1);
    end
    tend("random");
    summarize();
  end
endmodule
